// ==== hbt_target.sv ====
// hbt_target: target side of the 8-bit host bus; selection, command, data, status.
// assumes synchronous inputs; bus lines active low; tri-state resolved outside.
`timescale 1ns/100ps
module hbt_target #(
    parameter logic [2:0] MY_ADDR = hbt_pkg::ADDR_DEFAULT // which data line selects us
) (
    input  wire logic              mclk,
    input  wire logic              resetn,
    input  wire logic              sel_n,        // host select, active low
    input  wire logic              ack_n,        // host acknowledge, active low
    input  wire logic [7:0]        db_in_n,      // data bus as seen
    output logic [7:0]             db_out_n,     // data bus drive value
    output logic                   db_oe,        // data bus drive enable
    output hbt_pkg::hbt_ctl_t      ctl,          // busy, req and phase lines
    output logic                   ctl_oe,       // phase/busy lines driven
    output logic [7:0]             cmd_byte,     // command byte received
    output logic [2:0]             cmd_index,    // its position in the block
    output logic                   cmd_valid,    // one-cycle pulse per command byte
    output logic                   cmd_done,     // one-cycle pulse, block complete
    input  wire logic              data_in_req,  // user asks a host-to-device byte
    input  wire logic              data_out_req, // user offers a device-to-host byte
    input  wire logic [7:0]        data_out,     // byte to send
    output logic [7:0]             data_in,      // byte received in data phase
    output logic                   data_ack,     // one-cycle pulse per data byte
    input  wire logic              status_req,   // user asks to finish with status
    input  wire logic              exec_error,   // error during execution
    input  wire logic              lun,          // logical unit of drive
    output logic                   bus_free      // level, bus released
);
    import hbt_pkg::*;

    typedef enum {ST_FREE, ST_CMD, ST_CMD_WAIT, ST_EXEC, ST_DATA_WAIT,
                  ST_STAT0, ST_STAT0_WAIT, ST_STAT1, ST_STAT1_WAIT} hbt_st_t;

    typedef struct packed {
        hbt_st_t    st;        // bus phase sequencer
        hbt_ctl_t   ctl;       // registered line levels
        logic       ctl_oe;    // lines driven
        logic [2:0] idx;       // command byte count
        logic [7:0] cmd_byte;  // last command byte
        logic       cmd_valid; // command byte strobe
        logic       cmd_done;  // block complete strobe
        logic [7:0] din;       // last data byte in
        logic       dack;      // data byte strobe
        logic       dir_out;   // current data direction
        logic       free;      // bus released
    } hbt_top_t;

    hbt_top_t  s_reg;    // registered state
    hbt_top_t  s_next;   // next state
    hbt_xfer_t xfer;     // handshake start request
    logic      hs_done;  // handshake finished a byte
    logic      hs_req_n; // handshake request level
    logic [7:0] hs_rx;   // handshake captured byte
    logic [7:0] hs_db_n; // handshake bus drive
    logic      hs_oe;    // handshake bus enable
    logic [7:0] stat0;   // first status byte

    always_comb begin
        stat0          = 8'h00;
        stat0[ERR_BIT] = exec_error;
        stat0[LUN_BIT] = lun;
    end

    // byte handshake engine, shared by the command, data and status phases
    hbt_handshake u_hs (
        .mclk     (mclk),
        .resetn   (resetn),
        .xfer     (xfer),
        .ack_n    (ack_n),
        .db_in_n  (db_in_n),
        .req_n    (hs_req_n),
        .db_out_n (hs_db_n),
        .db_oe    (hs_oe),
        .done     (hs_done),
        .rx_byte  (hs_rx)
    );

    // phase sequencer
    always_comb begin
        s_next           = s_reg;
        s_next.cmd_valid = 1'b0;
        s_next.cmd_done  = 1'b0;
        s_next.dack      = 1'b0;
        xfer             = '{start: 1'b0, to_host: 1'b0, data: 8'h00};
        unique case (s_reg.st)
            ST_FREE: begin
                if (!sel_n && !db_in_n[MY_ADDR]) begin
                    s_next.ctl    = '{busy_n: 1'b0, req_n: 1'b1, io_n: 1'b1,
                                      cd_n: 1'b1, msg_n: 1'b1};
                    s_next.ctl_oe = 1'b1;
                    s_next.free   = 1'b0;
                    s_next.idx    = '0;
                    s_next.st     = ST_CMD;
                end
            end
            ST_CMD: begin
                s_next.ctl.cd_n = 1'b0;
                s_next.ctl.io_n = 1'b1;
                // step the position once the previous byte has been reported
                if (s_reg.cmd_valid) begin
                    s_next.idx = s_reg.idx + 3'h1;
                end
                // hold off the first request until select is withdrawn
                if (sel_n) begin
                    xfer.start = 1'b1;
                    s_next.st  = ST_CMD_WAIT;
                end
            end
            ST_CMD_WAIT: begin
                if (hs_done) begin
                    s_next.cmd_byte  = hs_rx;
                    s_next.cmd_valid = 1'b1;
                    if (s_reg.idx == 3'(CMD_BYTES - 1)) begin
                        s_next.cmd_done = 1'b1;
                        s_next.st       = ST_EXEC;
                    end else begin
                        s_next.st  = ST_CMD;
                    end
                end
            end
            ST_EXEC: begin
                s_next.ctl.cd_n = 1'b1;
                if (status_req) begin
                    s_next.st = ST_STAT0;
                end else if (data_out_req || data_in_req) begin
                    s_next.dir_out  = data_out_req;
                    s_next.ctl.io_n = ~data_out_req;
                    s_next.st       = ST_DATA_WAIT;
                    xfer = '{start: 1'b1, to_host: data_out_req, data: data_out};
                end
            end
            ST_DATA_WAIT: begin
                if (hs_done) begin
                    s_next.din  = hs_rx;
                    s_next.dack = 1'b1;
                    s_next.st   = ST_EXEC;
                end
            end
            ST_STAT0: begin
                s_next.ctl.cd_n = 1'b0;
                s_next.ctl.io_n = 1'b0;
                if (s_reg.ctl.cd_n == 1'b0 && s_reg.ctl.io_n == 1'b0) begin
                    xfer      = '{start: 1'b1, to_host: 1'b1, data: stat0};
                    s_next.st = ST_STAT0_WAIT;
                end
            end
            ST_STAT0_WAIT: begin
                if (hs_done) begin
                    s_next.st = ST_STAT1;
                end
            end
            ST_STAT1: begin
                xfer      = '{start: 1'b1, to_host: 1'b1, data: STATUS_LAST};
                s_next.st = ST_STAT1_WAIT;
            end
            ST_STAT1_WAIT: begin
                if (hs_done) begin
                    s_next.ctl    = '{busy_n: 1'b1, req_n: 1'b1, io_n: 1'b1,
                                      cd_n: 1'b1, msg_n: 1'b1};
                    s_next.ctl_oe = 1'b0;
                    s_next.free   = 1'b1;
                    s_next.st     = ST_FREE;
                end
            end
        endcase
    end

    // state register
    always_ff @(posedge mclk) begin
        if (!resetn) begin
            s_reg <= '{st: ST_FREE,
                       ctl: '{busy_n: 1'b1, req_n: 1'b1, io_n: 1'b1, cd_n: 1'b1,
                              msg_n: 1'b1},
                       ctl_oe: 1'b0, idx: 3'h0, cmd_byte: 8'h00, cmd_valid: 1'b0,
                       cmd_done: 1'b0, din: 8'h00, dack: 1'b0, dir_out: 1'b0,
                       free: 1'b1};
        end else begin
            s_reg <= s_next;
        end
    end

    // outputs: req and bus come straight from the handshake flip-flops
    always_comb begin
        ctl       = s_reg.ctl;
        ctl.req_n = hs_req_n;
    end
    assign ctl_oe    = s_reg.ctl_oe;
    assign db_out_n  = hs_db_n;
    assign db_oe     = hs_oe;
    assign cmd_byte  = s_reg.cmd_byte;
    assign cmd_index = s_reg.idx;
    assign cmd_valid = s_reg.cmd_valid;
    assign cmd_done  = s_reg.cmd_done;
    assign data_in   = s_reg.din;
    assign data_ack  = s_reg.dack;
    assign bus_free  = s_reg.free;

    // busy only rises when select and our address line were both low
    AST_BUSY_CAUSE: assert property (@(posedge mclk) disable iff (!resetn)
        $fell(ctl.busy_n) |-> $past(!sel_n && !db_in_n[MY_ADDR]))
        else $error("busy asserted without selection");

    // io stays high (host drives) while selection completes
    AST_SEL_IO: assert property (@(posedge mclk) disable iff (!resetn)
        $fell(ctl.busy_n) |-> ctl.io_n && ctl.req_n)
        else $error("io not released during selection");

    // every command request sees cd low, io high, msg high
    AST_CMD_LEVELS: assert property (@(posedge mclk) disable iff (!resetn)
        ($fell(ctl.req_n) && s_reg.st == ST_CMD_WAIT) |->
            (!ctl.cd_n && ctl.io_n && ctl.msg_n))
        else $error("command phase levels wrong at request");

    // command request within a bounded delay of select withdrawal
    AST_CMD_REQ_TIME: assert property (@(posedge mclk) disable iff (!resetn)
        (s_reg.st == ST_CMD && sel_n && ack_n) |-> ##[1:20] !ctl.req_n)
        else $error("command request late");

    // block completes after exactly six strobes
    AST_SIX_BYTES: assert property (@(posedge mclk) disable iff (!resetn)
        cmd_done |-> cmd_valid && cmd_index == 3'(CMD_BYTES - 1))
        else $error("command block length wrong");

    // incoming request release well within 1000 ns of ack
    AST_IN_DROP: assert property (@(posedge mclk) disable iff (!resetn)
        ($fell(ack_n) && !ctl.req_n && !db_oe) |-> ##[1:199] ctl.req_n)
        else $error("incoming request not released in time");

    // after the zero byte, busy and phase lines come free
    AST_BUS_RELEASE: assert property (@(posedge mclk) disable iff (!resetn)
        (s_reg.st == ST_STAT1_WAIT && hs_done) |=> (ctl.busy_n && !ctl_oe && bus_free))
        else $error("bus not released after status");
endmodule

// ==== hbt_pkg.sv ====
// hbt_pkg: shared constants and carrier types for the host bus target block.
// assumes a single 200 MHz clock (mclk) and a synchronous active-low reset.
// Summary of operation
// - busy asserts when select and address bit low
// - io released during selection, then command mode
// - command phase: cd low, io high, msg high
// - req asserted within 20 us of phase
// - six command bytes, one handshake each
// - outgoing data valid 125 ns before req
// - no timeout waiting for host ack
// - req drops 25 to 75 ns after ack
// - next outgoing req 1.2 to 1.7 us later
// - never req while ack; then 25-50 ns
// - incoming: req drops within 1000 ns of ack
// - incoming: next req within 500 ns
// - two status bytes end every command
// - status byte: bit1 error, bit5 unit
// - data line n addresses controller n
package hbt_pkg;
    localparam int unsigned CLK_PERIOD_PS   = 5000;      // 200 MHz clock period
    // timing figures as printed, in their own unit
    localparam int unsigned DATA_SETUP_NS   = 125;       // data before req
    localparam int unsigned REQ_DROP_MIN_NS = 25;        // req release after ack, least
    localparam int unsigned RE_REQ_MIN_NS   = 1200;      // outgoing re-request, least
    localparam int unsigned ACK_WAIT_MIN_NS = 25;        // req after ack release, least
    // derived cycle counts: least times round up
    localparam int unsigned SETUP_CYC   = (DATA_SETUP_NS * 1000 + CLK_PERIOD_PS - 1)
                                          / CLK_PERIOD_PS;
    localparam int unsigned DROP_CYC    = (REQ_DROP_MIN_NS * 1000 + CLK_PERIOD_PS - 1)
                                          / CLK_PERIOD_PS;
    localparam int unsigned RE_REQ_CYC  = (RE_REQ_MIN_NS * 1000 + CLK_PERIOD_PS - 1)
                                          / CLK_PERIOD_PS;
    localparam int unsigned ACK_GAP_CYC = (ACK_WAIT_MIN_NS * 1000 + CLK_PERIOD_PS - 1)
                                          / CLK_PERIOD_PS;
    localparam int unsigned CMD_BYTES   = 6;             // command block length
    localparam int unsigned ERR_BIT     = 1;             // status byte error flag
    localparam int unsigned LUN_BIT     = 5;             // status byte unit number
    localparam logic [7:0]  STATUS_LAST = 8'h00;         // completion byte
    localparam logic [2:0]  ADDR_DEFAULT = 3'h0;         // default controller address

    // phase line levels as driven on the cable (active low meaning in names)
    typedef struct packed {
        logic busy_n;   // busy, low = selected
        logic req_n;    // request, low = active
        logic io_n;     // high = host to controller
        logic cd_n;     // low = command/status
        logic msg_n;    // message, kept high
    } hbt_ctl_t;

    // pacing engine request toward the handshake leaf
    typedef struct packed {
        logic       start;   // begin one byte handshake
        logic       to_host; // direction of this byte
        logic [7:0] data;    // outgoing byte
    } hbt_xfer_t;
endpackage

// ==== hbt_handshake.sv ====
// hbt_handshake: one byte of req/ack handshake in either direction.
// assumes ack_n and db_in are synchronous to mclk; phase lines set by parent.
`timescale 1ns/100ps
module hbt_handshake (
    input  wire logic              mclk,
    input  wire logic              resetn,
    input  wire hbt_pkg::hbt_xfer_t xfer,     // start pulse with direction and byte
    input  wire logic              ack_n,     // host acknowledge, active low
    input  wire logic [7:0]        db_in_n,   // bus as seen, active low lines
    output logic                   req_n,     // request line, active low
    output logic [7:0]             db_out_n,  // bus drive value, active low
    output logic                   db_oe,     // bus drive enable
    output logic                   done,      // one-cycle pulse per byte
    output logic [7:0]             rx_byte    // byte captured from host
);
    import hbt_pkg::*;

    typedef enum {HS_IDLE, HS_SETUP, HS_WAIT_ACK_OFF, HS_GAP, HS_REQ, HS_DROP,
                  HS_PACE} hbt_hs_st_t;

    typedef struct packed {
        hbt_hs_st_t  st;      // handshake step
        logic [8:0]  cnt;     // pacing counter
        logic        to_host; // latched direction
        logic        req_n;   // request drive
        logic [7:0]  db_n;    // outgoing byte drive
        logic        oe;      // bus drive enable
        logic        done;    // byte finished
        logic [7:0]  rx;      // captured byte
    } hbt_hs_t;

    hbt_hs_t    s_reg;        // registered state
    hbt_hs_t    s_next;       // next state
    logic [8:0] pace_cnt_reg; // cycles since last outgoing release, saturating

    // checker helper: elapsed time since an outgoing request release
    always_ff @(posedge mclk) begin
        if (!resetn) begin
            pace_cnt_reg <= 9'h1ff;
        end else if (s_reg.st == HS_DROP && s_next.st == HS_PACE) begin
            pace_cnt_reg <= 9'h000;
        end else if (pace_cnt_reg != 9'h1ff) begin
            pace_cnt_reg <= pace_cnt_reg + 9'h001;
        end
    end

    // handshake sequencing
    always_comb begin
        s_next      = s_reg;
        s_next.done = 1'b0;
        unique case (s_reg.st)
            HS_IDLE: begin
                if (xfer.start) begin
                    s_next.to_host = xfer.to_host;
                    s_next.cnt     = '0;
                    s_next.db_n = ~xfer.data;
                    s_next.oe   = xfer.to_host;
                    s_next.st   = xfer.to_host ? HS_SETUP : HS_WAIT_ACK_OFF;
                end
            end
            HS_SETUP: begin
                // data held steady for the setup count before req may go
                s_next.cnt = s_reg.cnt + 9'h001;
                if (s_reg.cnt >= 9'(SETUP_CYC - 1)) begin
                    s_next.cnt = '0;
                    s_next.st  = HS_WAIT_ACK_OFF;
                end
            end
            HS_WAIT_ACK_OFF: begin
                if (ack_n) begin
                    s_next.cnt = s_next.cnt + 9'h001;
                    s_next.st  = HS_GAP;
                end
            end
            HS_GAP: begin
                if (!ack_n) begin
                    s_next.cnt = '0;
                    s_next.st  = HS_WAIT_ACK_OFF;
                end else if (s_reg.cnt >= 9'(ACK_GAP_CYC)) begin
                    s_next.req_n = 1'b0;
                    s_next.cnt   = '0;
                    s_next.st    = HS_REQ;
                end else begin
                    s_next.cnt = s_reg.cnt + 9'h001;
                end
            end
            HS_REQ: begin
                if (!ack_n) begin
                    s_next.cnt = '0;
                    s_next.st  = HS_DROP;
                    if (!s_reg.to_host) begin
                        s_next.rx = ~db_in_n;
                    end
                end
            end
            HS_DROP: begin
                s_next.cnt = s_reg.cnt + 9'h001;
                if (!s_reg.to_host) begin
                    // data may settle up to 25 ns after ack; track it until release
                    s_next.rx = ~db_in_n;
                end
                if (s_reg.cnt >= 9'(DROP_CYC - 1)) begin
                    s_next.req_n = 1'b1;
                    s_next.cnt   = '0;
                    s_next.st    = s_reg.to_host ? HS_PACE : HS_IDLE;
                    s_next.done  = ~s_reg.to_host;
                end
            end
            HS_PACE: begin
                s_next.cnt = s_reg.cnt + 9'h001;
                if (s_reg.cnt >= 9'(RE_REQ_CYC - 1)) begin
                    s_next.cnt  = '0;
                    s_next.done = 1'b1;
                    s_next.st   = HS_IDLE;
                end
            end
            default: s_next.st = HS_IDLE;
        endcase
    end

    // state register
    always_ff @(posedge mclk) begin
        if (!resetn) begin
            s_reg <= '{st: HS_IDLE, cnt: '0, to_host: 1'b0, req_n: 1'b1,
                       db_n: 8'hff, oe: 1'b0, done: 1'b0, rx: 8'h00};
        end else begin
            s_reg <= s_next;
        end
    end

    assign req_n    = s_reg.req_n;
    assign db_out_n = s_reg.db_n;
    assign db_oe    = s_reg.oe;
    assign done     = s_reg.done;
    assign rx_byte  = s_reg.rx;

    // request may only rise from idle while ack is inactive
    AST_REQ_NOT_WITH_ACK: assert property (@(posedge mclk) disable iff (!resetn)
        $fell(req_n) |-> $past(ack_n))
        else $error("request asserted while ack active");

    // request release follows ack by exactly the drop delay
    sequence hbt_ack_seen;
        !req_n && !ack_n && s_reg.st == HS_REQ;
    endsequence
    AST_REQ_DROP_TIME: assert property (@(posedge mclk) disable iff (!resetn)
        hbt_ack_seen |-> ##1 (!req_n) [*5] ##1 req_n)
        else $error("request release timing wrong");

    // outgoing data stands on the bus for setup before request
    AST_DATA_SETUP: assert property (@(posedge mclk) disable iff (!resetn)
        ($fell(req_n) && db_oe) |-> (db_out_n == $past(db_out_n, 25)) && $past(db_oe, 25))
        else $error("data setup before request too short");

    // outgoing re-request never sooner than the pacing gap
    AST_PACE_GAP: assert property (@(posedge mclk) disable iff (!resetn)
        ($fell(req_n) && s_reg.to_host) |-> (pace_cnt_reg >= 9'(RE_REQ_CYC)))
        else $error("outgoing request re-asserted too early");

    // request stays asserted while host has not answered
    AST_NO_TIMEOUT: assert property (@(posedge mclk) disable iff (!resetn)
        (!req_n && ack_n && s_reg.st == HS_REQ) |=> !req_n)
        else $error("request withdrawn without ack");
endmodule

// ==== hbt_host_model.sv ====
// hbt_host_model: behavioural host adapter facing the target.
// assumes a wired-and bus with pull-up; drives on falling edges.
`timescale 1ns/100ps
module hbt_host_model (
    input  wire logic              mclk,
    input  wire hbt_pkg::hbt_ctl_t ctl,
    input  wire logic [7:0]        db_n,
    output logic                   sel_n,
    output logic                   ack_n,
    output logic [7:0]             h_db_n
);
    import hbt_pkg::*;
    // idle: lines high, bus left to the pull-up
    initial begin
        sel_n = 1'b1;
        ack_n = 1'b1;
        h_db_n = 8'hff;
    end
    // bounded wait, a stuck target ends in the bench timeout
    task automatic wait_req(input logic lvl);
        for (int n = 0; n < 9000 && ctl.req_n !== lvl; n++) @(negedge mclk);
    endtask
    task automatic select(input int a, output logic got);
        wait (ctl.busy_n === 1'b1);
        @(negedge mclk);
        h_db_n = ~(8'h01 << a);
        repeat (21) @(negedge mclk);
        sel_n = 1'b0;
        repeat (4) @(negedge mclk);
        got = ~ctl.busy_n;
        sel_n = 1'b1;
        repeat (21) @(negedge mclk);
        h_db_n = 8'hff;
    endtask
    task automatic put(input logic [7:0] b, output logic [2:0] ph);
        wait_req(1'b0);
        ph = {ctl.io_n, ctl.cd_n, ctl.msg_n};
        repeat ($urandom_range(60)) @(negedge mclk);
        ack_n = 1'b0;
        h_db_n = ~b;
        wait_req(1'b1);
        h_db_n = 8'hff;
        repeat ($urandom_range(60)) @(negedge mclk);
        ack_n = 1'b1;
    endtask
    task automatic get(output logic [7:0] b, output logic [2:0] ph);
        wait_req(1'b0);
        ph = {ctl.io_n, ctl.cd_n, ctl.msg_n};
        repeat ($urandom_range(60)) @(negedge mclk);
        b = ~db_n;
        ack_n = 1'b0;
        wait_req(1'b1);
        @(negedge mclk);
        ack_n = 1'b1;
    endtask
endmodule

// ==== testbench.sv ====
// testbench: host model and user side around hbt_target.
// assumes one 200 MHz clock; bus is wired-and with pull-up.
`timescale 1ns/100ps
module testbench;
    import hbt_pkg::*;
    localparam logic [2:0] ADDR = 3'h5; // non-default address line
    logic       mclk, resetn, sel_n, ack_n, exec_error, lun, status_req, got;
    logic       data_in_req, data_out_req, db_oe, ctl_oe, cmd_valid, cmd_done;
    logic       data_ack, bus_free, prev_out;
    logic [7:0] data_out, data_in, db_out_n, h_db_n, cmd_byte;
    logic [2:0] cmd_index;
    hbt_ctl_t   ctl;
    wire  [7:0] db_n = (db_oe ? db_out_n : 8'hff) & h_db_n;
    int         fail_count, total_checks, cyc, t_rise, ncmd;
    logic [7:0] exp_cmd[$], exp_in[$];
    hbt_target #(.MY_ADDR(ADDR)) dut (.mclk(mclk), .resetn(resetn), .sel_n(sel_n),
        .ack_n(ack_n), .db_in_n(db_n), .db_out_n(db_out_n), .db_oe(db_oe), .ctl(ctl),
        .ctl_oe(ctl_oe), .cmd_byte(cmd_byte), .cmd_index(cmd_index),
        .cmd_valid(cmd_valid), .cmd_done(cmd_done), .data_in_req(data_in_req),
        .data_out_req(data_out_req), .data_out(data_out), .data_in(data_in),
        .data_ack(data_ack), .status_req(status_req), .exec_error(exec_error),
        .lun(lun), .bus_free(bus_free));
    hbt_host_model hst (.mclk(mclk), .ctl(ctl), .db_n(db_n), .sel_n(sel_n),
        .ack_n(ack_n), .h_db_n(h_db_n));
    initial mclk = 1'b0;
    always #2.5 mclk = ~mclk;
    task automatic chk(input logic [7:0] g, input logic [7:0] e, input string s);
        total_checks++;
        if (g !== e) begin
            fail_count++;
            $display("[FAIL] %0t %s got %h exp %h", $time, s, g, e);
        end
    endtask
    task automatic wrap_up();
        $display("checks %0d mismatches %0d", total_checks, fail_count);
        if (fail_count == 0 && total_checks > 0)
            $display("verification passed");
        else
            $display("verification failed");
        $finish;
    endtask
    // reference model: command and data queues, pacing, hang limit
    always @(posedge mclk) begin
        cyc++;
        if (cyc == 40000) begin
            fail_count++;
            wrap_up();
        end
        if (cmd_valid === 1'b1) begin
            chk(cmd_byte, exp_cmd.pop_front(), "cmd");
            chk({5'h0, cmd_index}, 8'(ncmd), "index");
            chk({7'h0, cmd_done}, 8'(ncmd == 5), "done");
            ncmd = (ncmd + 1) % 6;
        end
        if (data_ack === 1'b1 && exp_in.size() > 0) chk(data_in, exp_in.pop_front(), "in");
        if ($fell(ctl.req_n) && prev_out && ctl.io_n === 1'b0 && ctl.cd_n === 1'b1)
            chk(8'(cyc - t_rise >= 240 && cyc - t_rise <= 340), 8'h01, "gap");
        if ($rose(ctl.req_n)) begin
            t_rise = cyc;
            prev_out = ctl.io_n === 1'b0 && ctl.cd_n === 1'b1;
        end
    end
    // drop a user request once the target's req falls
    task automatic drop_at_req();
        wait (ctl.req_n === 1'b0);
        @(negedge mclk);
        data_out_req = 1'b0;
        data_in_req = 1'b0;
        status_req = 1'b0;
    endtask
    // one whole command: select, six bytes, data, two status bytes
    task automatic run_cmd(input int r);
        logic [7:0] b, g;
        logic [2:0] ph;
        hst.select(ADDR, got);
        chk({7'h0, got}, 8'h01, "select");
        for (int i = 0; i < 6; i++) begin
            b = $urandom;
            exp_cmd.push_back(b);
            hst.put(b, ph);
            chk({5'h0, ph}, 8'h05, "cmd phase");
        end
        for (int i = 0; i < 3; i++) begin
            b = $urandom;
            data_out = b;
            data_out_req = r[0];
            data_in_req = !r[0];
            if (!r[0]) exp_in.push_back(b);
            fork
                if (r[0]) hst.get(g, ph); else hst.put(b, ph);
                if (i == 2) drop_at_req();
            join
            if (r[0]) chk(g, b, "out");
            chk({5'h0, ph}, r[0] ? 8'h03 : 8'h07, "data phase");
        end
        exec_error = r[1];
        lun = r[0];
        status_req = 1'b1;
        fork
            hst.get(g, ph);
            drop_at_req();
        join
        chk(g, {2'h0, lun, 3'h0, exec_error, 1'b0}, "stat0");
        chk({5'h0, ph}, 8'h01, "stat phase");
        hst.get(g, ph);
        chk(g, 8'h00, "stat1");
        for (int n = 0; n < 400 && bus_free !== 1'b1; n++) @(negedge mclk);
        chk({1'b0, ctl, ctl_oe, bus_free}, 8'h7d, "free");
        $display("command %0d done", r);
    endtask
    // main sequence
    initial begin
        {resetn, data_in_req, data_out_req, status_req, exec_error, lun} = 6'h00;
        {data_out, fail_count, total_checks, cyc, ncmd, prev_out} = '0;
        void'($urandom(87325));
        repeat (3) @(negedge mclk);
        resetn = 1'b1;
        @(negedge mclk);
        chk({1'b0, ctl, ctl_oe, bus_free}, 8'h7d, "reset");
        $display("reset test done");
        repeat (5000) @(negedge mclk);
        hst.select(2, got);
        chk({7'h0, got}, 8'h00, "foreign");
        $display("address test done");
        for (int r = 0; r < 4; r++) run_cmd(r);
        wrap_up();
    end
endmodule
